// file: design/rtc_trim_map.svh
/*
 Register offsets, field positions, reset values and timing figures
 for the timekeeping core.
 Assumes inclusion by bare name from the design modules.
*/
`ifndef RTC_TRIM_MAP_SVH
`define RTC_TRIM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTC_ADDR_SECONDS_AND_HALT 3'h0
`define RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE 3'h1
`define RTC_ADDR_HOURS_COUNT 3'h2
`define RTC_ADDR_WEEKDAY_COUNT 3'h3
`define RTC_ADDR_DAY_OF_MONTH 3'h4
`define RTC_ADDR_CENTURY_AND_MONTH 3'h5
`define RTC_ADDR_YEAR_COUNT 3'h6
`define RTC_ADDR_TRIM_AND_OUTPUT_CONTROL 3'h7
`define RTC_LAST_CLOCK_ADDR 3'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RTC_OSC_HALT_BIT 7
`define RTC_OSC_FAIL_IRQ_ENABLE_BIT 7
`define RTC_OUT_LEVEL_BIT 7
`define RTC_FREQ_TEST_ENABLE_BIT 6
`define RTC_TRIM_SIGN_BIT 5
`define RTC_TRIM_MAG_MSB 4
`define RTC_TRIM_MAG_LSB 0
`define RTC_CENTURY_CODE_MSB 7
`define RTC_CENTURY_CODE_LSB 6
`define RTC_FT_DIV_BIT 5

// ----------------------------------------------------------------------
// Writable bits per offset
// ----------------------------------------------------------------------
`define RTC_MASK_SECONDS 8'hff
`define RTC_MASK_MINUTES 8'hff
`define RTC_MASK_HOURS 8'h3f
`define RTC_MASK_WEEKDAY 8'h07
`define RTC_MASK_DATE 8'h3f
`define RTC_MASK_MONTH 8'hdf
`define RTC_MASK_YEAR 8'hff
`define RTC_MASK_TRIM 8'hff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTC_CLOCK_RESET 8'h00
`define RTC_TRIM_RESET 8'h80

// ----------------------------------------------------------------------
// Divider chain and timing
// ----------------------------------------------------------------------
`define RTC_STAGE_LAST 9'h0ff
`define RTC_STAGE_LONG_LAST 9'h17f
`define RTC_STAGE_STEP 7'h01
`define RTC_STAGE_SPLIT_STEP 7'h02
`define RTC_SEC_IN_MIN_LAST 6'h3b
`define RTC_CLK_NS 25
`define RTC_OSC_STOP_NS 122070

`endif

// file: design/rtc_trim_pkg.sv
/*
 Types shared by the timekeeping core.
 Assumes the map header supplies all figures.
*/
package rtc_trim_pkg;

   typedef logic [7:0] reg_byte_t;

   typedef struct packed {
      logic [2:0] osc_sync;
      logic osc_level;
      logic [15:0] idle_cnt;
      logic stopped;
      logic [5:0] raw_div;
      logic [8:0] presc;
      logic [6:0] sub;
      logic [5:0] sec_in_min;
      logic [5:0] min_in_cycle;
      logic pending;
      logic [7:0][7:0] regs;
      reg_byte_t rd_data;
      logic irq_oe;
      logic ft_oe;
      logic pin_low;
   } rtc_state_t;

endpackage

// file: design/calendar_step.sv
/*
 One-second advance of the BCD time and date bytes with carries,
 month lengths, leap years and century count.
 Assumes bytes hold legal BCD values; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rtc_trim_map.svh"

module calendar_step (
   input wire logic [7:0] i_sec,
   input wire logic [7:0] i_min,
   input wire logic [7:0] i_hour,
   input wire logic [7:0] i_wday,
   input wire logic [7:0] i_date,
   input wire logic [7:0] i_mon,
   input wire logic [7:0] i_year,
   output logic [7:0] o_sec,
   output logic [7:0] o_min,
   output logic [7:0] o_hour,
   output logic [7:0] o_wday,
   output logic [7:0] o_date,
   output logic [7:0] o_mon,
   output logic [7:0] o_year
);

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {4'(v[7:4] + 4'h1), 4'h0};
      end
      return {v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction

   logic c_min, c_hour, c_day, c_mon, c_year, c_cent, leap;
   logic [1:0] century;
   logic [7:0] last_date;

   always_comb begin
      century = i_mon[`RTC_CENTURY_CODE_MSB:`RTC_CENTURY_CODE_LSB];
      // Leap when year divisible by four; 00 only in century code zero
      leap = (i_year[4] ? (i_year[3:0] == 4'h2 || i_year[3:0] == 4'h6)
                        : (i_year[3:0] == 4'h0 || i_year[3:0] == 4'h4 || i_year[3:0] == 4'h8))
             && (i_year != 8'h00 || century == 2'h0);
      if (i_mon[4:0] == 5'h02) begin
         last_date = leap ? 8'h29 : 8'h28;
      end else if (i_mon[4:0] == 5'h04 || i_mon[4:0] == 5'h06 || i_mon[4:0] == 5'h09 || i_mon[4:0] == 5'h11) begin
         last_date = 8'h30;
      end else begin
         last_date = 8'h31;
      end
      c_min = i_sec[6:0] == 7'h59;
      c_hour = c_min && i_min[6:0] == 7'h59;
      c_day = c_hour && i_hour[5:0] == 6'h23;
      c_mon = c_day && i_date[5:0] == last_date[5:0];
      c_year = c_mon && i_mon[4:0] == 5'h12;
      c_cent = c_year && i_year == 8'h99;
      o_sec = {i_sec[7], c_min ? 7'h00 : 7'(bcd_inc({1'b0, i_sec[6:0]}))};
      o_min = i_min;
      o_hour = i_hour;
      o_wday = i_wday;
      o_date = i_date;
      o_mon = i_mon;
      o_year = i_year;
      if (c_min) begin
         o_min = {i_min[7], c_hour ? 7'h00 : 7'(bcd_inc({1'b0, i_min[6:0]}))};
      end
      if (c_hour) begin
         o_hour = c_day ? 8'h00 : bcd_inc({2'h0, i_hour[5:0]});
      end
      if (c_day) begin
         o_wday = (i_wday[2:0] == 3'h7) ? 8'h01 : {5'h00, 3'(i_wday[2:0] + 3'h1)};
         o_date = c_mon ? 8'h01 : bcd_inc({2'h0, i_date[5:0]});
      end
      if (c_mon) begin
         o_mon = {2'(century + {1'b0, c_cent}), 1'b0,
                  c_year ? 5'h01 : 5'(bcd_inc({3'h0, i_mon[4:0]}))};
      end
      if (c_year) begin
         o_year = c_cent ? 8'h00 : bcd_inc(i_year);
      end
   end

endmodule
`default_nettype wire

// file: design/rtc_core.sv
/*
 Timekeeping core: eight-byte register file, divider chain with
 pulse trim at the divide-by-256 stage, 512 Hz test pin, shared
 level/interrupt pin and oscillator stop detection.
 Assumes a serial bus engine on the same clock drives the register
 port, and the crystal oscillator output arrives as an async pin.
*/
// Contract
// - Trim only at divide-by-256 stage
// - Five-bit trim magnitude at offset seven
// - Bit 5 selects faster or slower
// - One corrected second per minute, 64-minute cycle
// - Correct first 2N minutes of cycle
// - Step equals +128 or -256 crystal cycles per corrected minute
// - Test pin toggles 512 Hz when enabled
// - Test pin taken before trim
// - Century code counts at year wrap
// - Leap every fourth year, 00 only in century code zero
// - Shared pin follows level bit
// - Shared pin signals oscillator fail
// - Halt bit counts as oscillator stop
// - Fail held until disabled or restarted
// - Power-on: level one, controls zero
// - Halt bit stops oscillator counting
// - Clock write reloads, clears divider
// - Time fields held in BCD
`timescale 1ns/100ps
`default_nettype none
`include "rtc_trim_map.svh"

module rtc_core #(
   parameter int unsigned STOP_CYC = (`RTC_OSC_STOP_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS,
   parameter int unsigned STAGE_LAST = `RTC_STAGE_LAST
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_osc_in,
   input wire logic [2:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_clock_read_hold,
   output logic [7:0] o_rd_data,
   output logic o_osc_stopped,
   output logic o_fail_irq_or_level_pin_o,
   output logic o_fail_irq_or_level_pin_oe,
   output logic o_freq_test_pin_o,
   output logic o_freq_test_pin_oe
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (STOP_CYC < 2 || STOP_CYC > 65535) begin : g_bad_stop_cyc
      $error("STOP_CYC must lie in 2..65535");
   end
   if (STAGE_LAST < 1 || STAGE_LAST > 255) begin : g_bad_stage_last
      $error("STAGE_LAST must lie in 1..255");
   end

   localparam logic [15:0] STOP_LAST = 16'(STOP_CYC - 1);
   // Shorter stage only to speed up simulation
   localparam logic [8:0] STAGE_END = 9'(STAGE_LAST);
   localparam logic [8:0] STAGE_LONG_END = 9'(STAGE_LAST + `RTC_STAGE_LONG_LAST - `RTC_STAGE_LAST);

   // ----------------------------------------------------------------------
   // State and working signals
   // ----------------------------------------------------------------------
   rtc_trim_pkg::rtc_state_t st_ff;
   rtc_trim_pkg::rtc_state_t nxt_st;

   logic osc_edge;
   logic run_tick;
   logic halt;
   logic fail_en;
   logic out_level;
   logic ft_en;
   logic trim_sign;
   logic [4:0] trim_mag;
   logic osc_fail;
   logic corr_sec;
   logic [8:0] stage_last;
   logic [6:0] stage_step;
   logic [7:0] sub_sum;
   logic sec_pulse;
   logic due;
   logic clock_wr;
   logic [7:0] adv_sec, adv_min, adv_hour, adv_wday, adv_date, adv_mon, adv_year;

   function automatic logic [7:0] wr_mask(input logic [2:0] a);
      unique case (a)
         `RTC_ADDR_SECONDS_AND_HALT: return `RTC_MASK_SECONDS;
         `RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE: return `RTC_MASK_MINUTES;
         `RTC_ADDR_HOURS_COUNT: return `RTC_MASK_HOURS;
         `RTC_ADDR_WEEKDAY_COUNT: return `RTC_MASK_WEEKDAY;
         `RTC_ADDR_DAY_OF_MONTH: return `RTC_MASK_DATE;
         `RTC_ADDR_CENTURY_AND_MONTH: return `RTC_MASK_MONTH;
         `RTC_ADDR_YEAR_COUNT: return `RTC_MASK_YEAR;
         `RTC_ADDR_TRIM_AND_OUTPUT_CONTROL: return `RTC_MASK_TRIM;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Calendar advance
   // ----------------------------------------------------------------------
   calendar_step u_calendar_step (
      .i_sec(st_ff.regs[`RTC_ADDR_SECONDS_AND_HALT]),
      .i_min(st_ff.regs[`RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE]),
      .i_hour(st_ff.regs[`RTC_ADDR_HOURS_COUNT]),
      .i_wday(st_ff.regs[`RTC_ADDR_WEEKDAY_COUNT]),
      .i_date(st_ff.regs[`RTC_ADDR_DAY_OF_MONTH]),
      .i_mon(st_ff.regs[`RTC_ADDR_CENTURY_AND_MONTH]),
      .i_year(st_ff.regs[`RTC_ADDR_YEAR_COUNT]),
      .o_sec(adv_sec),
      .o_min(adv_min),
      .o_hour(adv_hour),
      .o_wday(adv_wday),
      .o_date(adv_date),
      .o_mon(adv_mon),
      .o_year(adv_year)
   );

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // Control fields
      halt = st_ff.regs[`RTC_ADDR_SECONDS_AND_HALT][`RTC_OSC_HALT_BIT];
      fail_en = st_ff.regs[`RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE][`RTC_OSC_FAIL_IRQ_ENABLE_BIT];
      out_level = st_ff.regs[`RTC_ADDR_TRIM_AND_OUTPUT_CONTROL][`RTC_OUT_LEVEL_BIT];
      ft_en = st_ff.regs[`RTC_ADDR_TRIM_AND_OUTPUT_CONTROL][`RTC_FREQ_TEST_ENABLE_BIT];
      trim_sign = st_ff.regs[`RTC_ADDR_TRIM_AND_OUTPUT_CONTROL][`RTC_TRIM_SIGN_BIT];
      trim_mag = st_ff.regs[`RTC_ADDR_TRIM_AND_OUTPUT_CONTROL][`RTC_TRIM_MAG_MSB:`RTC_TRIM_MAG_LSB];

      // Oscillator pin: three flops, edge once second and third agree
      nxt_st.osc_sync = {st_ff.osc_sync[1:0], i_osc_in};
      osc_edge = 1'b0;
      if (st_ff.osc_sync[1] == st_ff.osc_sync[2] && st_ff.osc_sync[2] != st_ff.osc_level) begin
         nxt_st.osc_level = st_ff.osc_sync[2];
         osc_edge = st_ff.osc_sync[2];
      end
      run_tick = osc_edge & ~halt;

      // Stop detection: no rising edge within the timeout
      if (osc_edge) begin
         nxt_st.idle_cnt = 16'h0000;
         nxt_st.stopped = 1'b0;
      end else if (st_ff.idle_cnt != STOP_LAST) begin
         nxt_st.idle_cnt = 16'(st_ff.idle_cnt + 16'h0001);
      end else begin
         nxt_st.stopped = 1'b1;
      end
      osc_fail = halt | st_ff.stopped;

      // Untrimmed divider for the test pin
      if (osc_edge) begin
         nxt_st.raw_div = 6'(st_ff.raw_div + 6'h01);
      end

      // Trim window: first 2N minutes, first second, first stage period
      corr_sec = (st_ff.min_in_cycle < {trim_mag, 1'b0})
                 && (st_ff.sec_in_min == 6'h00)
                 && (st_ff.sub == 7'h00);
      // Slower: stage stretched by 128; faster: stage output split in two
      stage_last = (corr_sec && !trim_sign) ? STAGE_LONG_END : STAGE_END;
      stage_step = (corr_sec && trim_sign) ? `RTC_STAGE_SPLIT_STEP : `RTC_STAGE_STEP;
      sub_sum = {1'b0, st_ff.sub} + {1'b0, stage_step};
      sec_pulse = 1'b0;
      if (run_tick) begin
         if (st_ff.presc == stage_last) begin
            nxt_st.presc = 9'h000;
            nxt_st.sub = sub_sum[6:0];
            sec_pulse = sub_sum[7];
         end else begin
            nxt_st.presc = 9'(st_ff.presc + 9'h001);
         end
      end

      // Position inside the 64-minute trim cycle
      if (sec_pulse) begin
         if (st_ff.sec_in_min == `RTC_SEC_IN_MIN_LAST) begin
            nxt_st.sec_in_min = 6'h00;
            nxt_st.min_in_cycle = 6'(st_ff.min_in_cycle + 6'h01);
         end else begin
            nxt_st.sec_in_min = 6'(st_ff.sec_in_min + 6'h01);
         end
      end

      // Seconds update, deferred while a clock byte is being read
      clock_wr = i_wr_en && (i_addr <= `RTC_LAST_CLOCK_ADDR);
      due = sec_pulse | st_ff.pending;
      nxt_st.pending = due && i_clock_read_hold && !clock_wr;
      if (due && !i_clock_read_hold && !clock_wr) begin
         nxt_st.regs[`RTC_ADDR_SECONDS_AND_HALT] = adv_sec;
         nxt_st.regs[`RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE] = adv_min;
         nxt_st.regs[`RTC_ADDR_HOURS_COUNT] = adv_hour;
         nxt_st.regs[`RTC_ADDR_WEEKDAY_COUNT] = adv_wday;
         nxt_st.regs[`RTC_ADDR_DAY_OF_MONTH] = adv_date;
         nxt_st.regs[`RTC_ADDR_CENTURY_AND_MONTH] = adv_mon;
         nxt_st.regs[`RTC_ADDR_YEAR_COUNT] = adv_year;
      end

      // Register write; any clock byte restarts the divider chain
      if (i_wr_en) begin
         nxt_st.regs[i_addr] = i_wr_data & wr_mask(i_addr);
         if (clock_wr) begin
            nxt_st.presc = 9'h000;
            nxt_st.sub = 7'h00;
         end
      end

      // Read data, one cycle after the address
      nxt_st.rd_data = st_ff.regs[i_addr];

      // Shared pin: fail interrupt when enabled, else level bit
      if (fail_en) begin
         nxt_st.irq_oe = osc_fail;
      end else begin
         nxt_st.irq_oe = ~out_level;
      end

      // Test pin: pulls low on the low half of the 512 Hz square
      if (!halt && out_level && ft_en) begin
         nxt_st.ft_oe = ~st_ff.raw_div[`RTC_FT_DIV_BIT];
      end else begin
         nxt_st.ft_oe = 1'b0;
      end
      nxt_st.pin_low = 1'b0;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_ff <= '0;
         st_ff.regs[`RTC_ADDR_SECONDS_AND_HALT] <= `RTC_CLOCK_RESET;
         st_ff.regs[`RTC_ADDR_MINUTES_AND_FAIL_IRQ_ENABLE] <= `RTC_CLOCK_RESET;
         st_ff.regs[`RTC_ADDR_TRIM_AND_OUTPUT_CONTROL] <= `RTC_TRIM_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_rd_data = st_ff.rd_data;
   assign o_osc_stopped = st_ff.stopped;
   assign o_fail_irq_or_level_pin_o = st_ff.pin_low;
   assign o_fail_irq_or_level_pin_oe = st_ff.irq_oe;
   assign o_freq_test_pin_o = st_ff.pin_low;
   assign o_freq_test_pin_oe = st_ff.ft_oe;

endmodule
`default_nettype wire

// file: testbench/rtc_host_model.sv
/* Host side: register master that keeps fixed-zero bits clear, plus crystal pin.
   Assumes the core samples its inputs on rising i_clk. */
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model #(parameter int HALF = 2) (
   input wire logic i_clk,
   input wire logic [7:0] i_rd_data,
   output logic [2:0] o_addr,
   output logic o_wr_en,
   output logic [7:0] o_wr_data,
   output logic o_osc
);
   logic run = 1'b1;
   int ph = 0;
   initial begin
      o_addr = 3'h0;
      o_wr_en = 1'b0;
      o_wr_data = 8'h00;
      o_osc = 1'b0;
   end
   // Crystal stands still while run is low
   always @(negedge i_clk) begin
      ph = run ? ph + 1 : ph;
      if (ph == HALF) begin
         ph = 0;
         o_osc = !o_osc;
      end
   end
   function automatic logic [7:0] fixed_mask(input logic [2:0] a);
      case (a)
         3'h2, 3'h4: return 8'h3f;
         3'h3: return 8'h07;
         3'h5: return 8'hdf;
         default: return 8'hff;
      endcase
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wr_data = d & fixed_mask(a);
      o_wr_en = 1'b1;
      @(negedge i_clk);
      o_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      @(negedge i_clk);
      o_addr = a;
      repeat (2) @(negedge i_clk);
      q = i_rd_data;
   endtask
endmodule
`default_nettype wire

// file: testbench/rtc_core_sva.sv
/* Port checker for rtc_core, bound into every instance.
   Assumes writes keep fixed-zero bits clear. */
`timescale 1ns/100ps
`default_nettype none
module rtc_core_chk #(parameter int unsigned STOP_CYC = 4883) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_osc_in,
   input wire logic [2:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic [7:0] o_rd_data,
   input wire logic o_osc_stopped,
   input wire logic o_fail_irq_or_level_pin_o,
   input wire logic o_fail_irq_or_level_pin_oe,
   input wire logic o_freq_test_pin_o,
   input wire logic o_freq_test_pin_oe
);
   logic [7:0] trim_ff;
   logic halt_ff, fie_ff, osc_ff;
   logic [15:0] idle_ff;
   // Shadow of control bits, clocks since last crystal rise
   always_ff @(posedge i_clk) begin
      osc_ff <= i_osc_in;
      if (i_reset) begin
         trim_ff <= 8'h80;
         halt_ff <= 1'b0;
         fie_ff <= 1'b0;
         idle_ff <= 16'h0;
      end else begin
         if (i_wr_en && i_addr == 3'h7) trim_ff <= i_wr_data;
         if (i_wr_en && i_addr == 3'h0) halt_ff <= i_wr_data[7];
         if (i_wr_en && i_addr == 3'h1) fie_ff <= i_wr_data[7];
         idle_ff <= (i_osc_in && !osc_ff) ? 16'h0 : idle_ff + 16'h1;
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   sequence s_wr7;
      i_wr_en && i_addr == 3'h7 ##1 i_addr == 3'h7;
   endsequence
   sequence s_osc_back;
      $rose(i_osc_in);
   endsequence
   property p_wr7;
      s_wr7 |=> o_rd_data == $past(i_wr_data, 2);
   endproperty
   a_wr7: assert property (p_wr7) else $error("trim byte read-back wrong");
   property p_rd7;
      !$past(i_reset) && $past(i_addr) == 3'h7 |-> o_rd_data == $past(trim_ff);
   endproperty
   a_rd7: assert property (p_rd7) else $error("trim byte read wrong");
   property p_level;
      !$past(i_reset) && !$past(fie_ff) |-> o_fail_irq_or_level_pin_oe == !$past(trim_ff[7]);
   endproperty
   a_level: assert property (p_level) else $error("level pin wrong");
   property p_fail;
      !$past(i_reset) && $past(fie_ff) |-> o_fail_irq_or_level_pin_oe == ($past(halt_ff) || $past(o_osc_stopped));
   endproperty
   a_fail: assert property (p_fail) else $error("fail pin wrong");
   property p_ft_off;
      !$past(i_reset) && !(!$past(halt_ff) && $past(trim_ff[7]) && $past(trim_ff[6])) |-> !o_freq_test_pin_oe;
   endproperty
   a_ft_off: assert property (p_ft_off) else $error("test pin driven while off");
   property p_od_val;
      !o_fail_irq_or_level_pin_o && !o_freq_test_pin_o;
   endproperty
   a_od_val: assert property (p_od_val) else $error("open drain value high");
   property p_stop_rise;
      $rose(o_osc_stopped) |-> idle_ff >= STOP_CYC;
   endproperty
   a_stop_rise: assert property (p_stop_rise) else $error("stop flagged early");
   property p_stop_clear;
      s_osc_back |-> ##[1:8] !o_osc_stopped;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop flag held");
endmodule
bind rtc_core rtc_core_chk #(.STOP_CYC(STOP_CYC)) chk (.i_clk(i_clk), .i_reset(i_reset), .i_osc_in(i_osc_in),
   .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
   .o_osc_stopped(o_osc_stopped), .o_fail_irq_or_level_pin_o(o_fail_irq_or_level_pin_o),
   .o_fail_irq_or_level_pin_oe(o_fail_irq_or_level_pin_oe), .o_freq_test_pin_o(o_freq_test_pin_o),
   .o_freq_test_pin_oe(o_freq_test_pin_oe));
`default_nettype wire

// file: testbench/tb_rtc_core.sv
/* Self-checking bench for rtc_core, calendar reached through its registers.
   Assumes rtc_host_model drives the register port and crystal pin. */
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_core;
   localparam int STOP = 50;
   localparam int HALF = 2;
   // Shortened stage: one second is 128 stages of STAGE + 1 crystal periods
   localparam int STAGE = 3;
   localparam int SEC_CLK = 128 * (STAGE + 1) * 2 * HALF;
   logic i_clk, i_reset, osc, wr_en, stopped, irq_o, irq_oe, ft_o, ft_oe;
   logic [2:0] addr;
   logic [7:0] wr_data, rd_data, q, d;
   logic [55:0] got;
   logic [31:0] lfsr_ff = 32'hf76a;
   logic [111:0] cal_tab [9];
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   // Pull-ups on both open-drain pins
   wire logic irq_wire = irq_oe ? irq_o : 1'b1;
   wire logic ft_wire = ft_oe ? ft_o : 1'b1;
   rtc_core #(.STOP_CYC(STOP), .STAGE_LAST(STAGE)) uut (.i_clk(i_clk), .i_reset(i_reset), .i_osc_in(osc), .i_addr(addr),
      .i_wr_en(wr_en), .i_wr_data(wr_data), .i_clock_read_hold(1'b0), .o_rd_data(rd_data),
      .o_osc_stopped(stopped), .o_fail_irq_or_level_pin_o(irq_o), .o_fail_irq_or_level_pin_oe(irq_oe),
      .o_freq_test_pin_o(ft_o), .o_freq_test_pin_oe(ft_oe));
   rtc_host_model #(.HALF(HALF)) host (.i_clk(i_clk), .i_rd_data(rd_data), .o_addr(addr), .o_wr_en(wr_en),
      .o_wr_data(wr_data), .o_osc(osc));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rand_bcd(input logic [31:0] s);
      return {1'b0, 3'(s[10:8] % 3'h6), 4'(s[3:0] % 4'ha)};
   endfunction
   // Test pin half period: 32 crystal periods
   function automatic int exp_half(input int h);
      return 32 * 2 * h;
   endfunction
   task automatic chk_val(input logic [55:0] got, input logic [55:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      compares++;
      if (got != exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic measure(output int m);
      logic s;
      for (int i = 0; i < 2; i++) begin
         s = ft_oe;
         m = 0;
         while (ft_oe === s && m < 400) begin
            @(negedge i_clk);
            m++;
         end
      end
   endtask
   task automatic ft_idle();
      for (int i = 0; i < 4; i++) begin
         repeat (40) @(negedge i_clk);
         chk_val(56'(ft_wire), 56'h1);
      end
   endtask
   task automatic final_report();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 25000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      cal_tab = '{112'h59592307311299_00000001014100, 112'h5959230331d299_00000004010100,
         112'h59592301280204_00000002290204, 112'h59592301280200_00000002290200,
         112'h59592301284200_00000002014300, 112'h59592301290204_00000002010304,
         112'h59592301300405_00000002010505, 112'h59091302150621_00101302150621,
         112'h59592301280205_00000002010305};
      i_reset = 1'b1;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_reset = 1'b0;
      for (int a = 0; a < 8; a++) begin
         host.rd(3'(a), q);
         chk_val(56'(q), (a == 7) ? 56'h80 : 56'h0);
      end
      chk_val(56'({irq_wire, ft_wire}), 56'h3);
      $display("test reset_values done");
      for (int i = 0; i < 32; i++) begin
         lfsr_ff = lfsr_next(lfsr_ff);
         d = (lfsr_ff[2:0] == 3'h7) ? lfsr_ff[23:16] : rand_bcd(lfsr_ff);
         host.wr(lfsr_ff[2:0], d);
         host.rd(lfsr_ff[2:0], q);
         chk_val(56'(q), 56'(d & host.fixed_mask(lfsr_ff[2:0])));
      end
      $display("test random_regs done");
      for (int i = 0; i < 4; i++) begin
         d = i[0] ? 8'h80 : 8'h00;
         host.wr(3'h7, d);
         repeat (3) @(negedge i_clk);
         chk_val(56'(irq_wire), 56'(d[7]));
      end
      $display("test level_pin done");
      host.wr(3'h0, 8'h00);
      host.wr(3'h7, 8'hc0);
      measure(n);
      chk_cnt(n, exp_half(HALF));
      host.wr(3'h7, 8'hff);
      measure(n);
      chk_cnt(n, exp_half(HALF));
      host.wr(3'h7, 8'h80);
      ft_idle();
      host.wr(3'h7, 8'hc0);
      host.wr(3'h0, 8'h80);
      ft_idle();
      $display("test freq_pin done");
      // Trim off, so each second lasts SEC_CLK clocks after the last write
      host.wr(3'h7, 8'h80);
      foreach (cal_tab[i]) begin
         for (int a = 0; a < 7; a++) begin
            host.wr(3'(a), cal_tab[i][111 - 8 * a -: 8]);
         end
         repeat (SEC_CLK + 12) @(negedge i_clk);
         for (int a = 0; a < 7; a++) begin
            host.rd(3'(a), q);
            got = {got[47:0], q};
         end
         chk_val(got, cal_tab[i][55:0]);
      end
      $display("test calendar done");
      host.wr(3'h0, 8'h00);
      // Crystal has run for several seconds by now
      host.wr(3'h1, 8'h80);
      repeat (3) @(negedge i_clk);
      chk_val(56'({stopped, irq_wire}), 56'h1);
      host.run = 1'b0;
      repeat (STOP + 10) @(negedge i_clk);
      chk_val(56'({stopped, irq_wire}), 56'h2);
      host.run = 1'b1;
      repeat (20) @(negedge i_clk);
      chk_val(56'({stopped, irq_wire}), 56'h1);
      host.wr(3'h0, 8'h80);
      repeat (3) @(negedge i_clk);
      chk_val(56'(irq_wire), 56'h0);
      host.wr(3'h1, 8'h00);
      repeat (3) @(negedge i_clk);
      chk_val(56'(irq_wire), 56'h1);
      $display("test osc_fail done");
      final_report();
   end
endmodule
`default_nettype wire
